// >>> shared/sat_map.svh
// Register offsets, field positions, reset values and widths of the segment translator
`ifndef SAT_MAP_SVH
`define SAT_MAP_SVH
`define SAT_OFF_CTRL 8'h00
`define SAT_OFF_CTRL_FOUR 8'h04
`define SAT_OFF_GLOBAL_LO 8'h08
`define SAT_OFF_GLOBAL_HI 8'h0C
`define SAT_OFF_LOCAL_LO 8'h10
`define SAT_OFF_LOCAL_HI 8'h14
`define SAT_OFF_IDQ 8'h18
`define SAT_OFF_STATUS 8'h1C
`define SAT_OFF_SEL_BASE 8'h20
`define SAT_OFF_SEL_LAST 8'h34
`define SAT_CTRL_LONG 0
`define SAT_CTRL_PAGING 1
`define SAT_CTRL_FOUR_EXT 5
`define SAT_CTRL_RESET 32'h0000_0000
`define SAT_CTRL_FOUR_RESET 32'h0000_0000
`define SAT_SEL_RESET 16'h0000
`define SAT_SEL_PRIV_MSB 1
`define SAT_SEL_TABLE 2
`define SAT_SEL_IDX_LSB 3
`define SAT_DESC_SHIFT 3
`define SAT_PA_LEGACY 32
`define SAT_PA_EXT 36
`define SAT_STATUS_BUSY 8
`endif

// >>> shared/sat_pkg.sv
// Types shared by the segment translator and its bench
package sat_pkg;
  typedef enum logic [2:0] {
    SEG_CODE = 3'h0, SEG_STACK = 3'h1, SEG_DATA = 3'h2,
    SEG_EXTRA = 3'h3, SEG_AUX_ONE = 3'h4, SEG_AUX_TWO = 3'h5
  } sat_seg_e;
  typedef enum logic [2:0] {
    FLT_NONE = 3'h0, FLT_NULL_LOAD = 3'h1, FLT_NULL_USE = 3'h2, FLT_LIMIT = 3'h3,
    FLT_RIGHTS = 3'h4, FLT_CANON = 3'h5, FLT_NOT_PRESENT = 3'h6
  } sat_fault_e;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_FETCH = 2'b10
  } sat_state_e;
  // Hidden cached part of one segment register
  typedef struct packed {
    logic [63:0] base;
    logic [31:0] limit;
    logic [7:0] access;
    logic longCode;
    logic isNull;
  } sat_cache_s;
  // One memory reference from the pipeline
  typedef struct packed {
    sat_seg_e seg;
    logic [63:0] offset;
    logic write;
    logic exec;
  } sat_acc_s;
endpackage

// >>> logic/sat_translator.sv
// Segment selector decode, descriptor caching, access checks and linear address forming
`timescale 1ns/1ps
`include "sat_map.svh"
module sat_translator
  import sat_pkg::*;
#(
  parameter int PHYS_WIDTH = 36,
  parameter int VA_WIDTH = 48
)
(
  input wire logic clk,
  input wire logic reset,
  input wire logic clkEn,
  // Register port
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdData,
  // Descriptor fetch toward memory
  output logic descReqValid,
  output logic [63:0] descReqAddr,
  input wire logic descRspValid,
  input wire logic [63:0] descRspData,
  // Memory reference from the pipeline
  input wire logic accValid,
  input wire sat_acc_s accReq,
  // Direct physical address when paging is off
  output logic physValid,
  output logic [63:0] physAddr,
  // Linear address handed to the paging stage
  output logic pageReqValid,
  output logic [63:0] pageLinAddr,
  // Fault report to the exception unit
  output logic faultValid,
  output sat_fault_e faultCode,
  output logic [1:0] faultPriv,
  output logic busy
);

  localparam int SEG_COUNT = 6;
  localparam int CANON_SHIFT = 64 - VA_WIDTH;

  // Widths the address logic cannot serve are reported by an error at the start of simulation
  initial
  begin
    if (PHYS_WIDTH < 32 || PHYS_WIDTH > 52 || VA_WIDTH < 32 || VA_WIDTH > 63)
    begin
      $error("sat_translator: unsupported address width parameter");
    end
  end

  // Software visible state and the hidden segment caches
  logic [31:0] ctrl_q;
  logic [31:0] ctrlFour_q;
  logic [63:0] globalBase_q;
  logic [63:0] localBase_q;
  logic [15:0] selector_q [SEG_COUNT];
  sat_cache_s cache_q [SEG_COUNT];
  sat_fault_e lastFault_q;
  logic [31:0] rdData_q;

  // Load sequencer state
  sat_state_e state_q;
  sat_state_e state_d;
  logic [2:0] pendSeg_q;
  logic [15:0] pendSel_q;

  // Registered translation results
  logic physValid_q;
  logic [63:0] physAddr_q;
  logic pageValid_q;
  logic [63:0] pageAddr_q;

  // Address decode of the register port
  wire logic hitCtrl = regAddr == `SAT_OFF_CTRL;
  wire logic hitCtrlFour = regAddr == `SAT_OFF_CTRL_FOUR;
  wire logic hitGlobalLo = regAddr == `SAT_OFF_GLOBAL_LO;
  wire logic hitGlobalHi = regAddr == `SAT_OFF_GLOBAL_HI;
  wire logic hitLocalLo = regAddr == `SAT_OFF_LOCAL_LO;
  wire logic hitLocalHi = regAddr == `SAT_OFF_LOCAL_HI;
  wire logic hitIdq = regAddr == `SAT_OFF_IDQ;
  wire logic hitStatus = regAddr == `SAT_OFF_STATUS;
  wire logic hitSel = regAddr >= `SAT_OFF_SEL_BASE && regAddr <= `SAT_OFF_SEL_LAST && regAddr[1:0] == 2'b00;
  wire logic [7:0] selOffset = regAddr - `SAT_OFF_SEL_BASE;
  wire logic [2:0] selIdx = selOffset[4:2];

  // Selector fields of a selector being written
  // index bits 15-3
  wire logic [12:0] wrIndex = regWrData[15:`SAT_SEL_IDX_LSB];
  wire logic wrTableSel = regWrData[`SAT_SEL_TABLE];
  wire logic [1:0] wrPriv = regWrData[`SAT_SEL_PRIV_MSB:0];
  wire logic wrIsNull = wrIndex == 13'h0000 && !wrTableSel;
  wire logic wrCodeOrStack = selIdx == SEG_CODE || selIdx == SEG_STACK;

  // A selector write is refused while a fetch is in flight
  wire logic selWrite = clkEn && regWr && hitSel && state_q == ST_IDLE;
  wire logic nullLoadFault = selWrite && wrIsNull && wrCodeOrStack;
  wire logic nullLoadOk = selWrite && wrIsNull && !wrCodeOrStack;
  // fetch only on a selector load
  wire logic startFetch = selWrite && !wrIsNull;

  // descriptor address is table base plus eight times index
  // bit 2 picks the local table
  wire logic [63:0] tableBase = wrTableSel ? localBase_q : globalBase_q;
  wire logic [63:0] descAddr = tableBase + {48'h0000_0000_0000, wrIndex, 3'b000};

  // Descriptor fields; two limit parts form a 20-bit value
  wire logic [31:0] rspBase = {descRspData[63:56], descRspData[39:16]};
  wire logic [19:0] rspLimit20 = {descRspData[51:48], descRspData[15:0]};
  wire logic [7:0] rspAccess = descRspData[47:40];
  wire logic rspGran = descRspData[55];
  wire logic rspLong = descRspData[53];
  wire logic [31:0] rspLimit = rspGran ? {rspLimit20, 12'hFFF} : {12'h000, rspLimit20};
  wire logic rspTaken = clkEn && state_q == ST_FETCH && descRspValid;
  wire logic rspAbsent = !rspAccess[7];
  wire logic rspFault = rspTaken && rspAbsent;

  // Fetch sequencer: one descriptor in flight at a time
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      ST_IDLE:
        if (startFetch)
          state_d = ST_FETCH;
      ST_FETCH:
        if (descRspValid)
          state_d = ST_IDLE;
      default:
        state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      state_q <= ST_IDLE;
      pendSeg_q <= 3'h0;
      pendSel_q <= `SAT_SEL_RESET;
    end
    else if (clkEn)
    begin
      state_q <= state_d;
      if (startFetch)
      begin
        pendSeg_q <= selIdx;
        pendSel_q <= regWrData[15:0];
      end
    end
  end

  // Per-segment visible selector and hidden cache
  genvar g;
  generate
    for (g = 0; g < SEG_COUNT; g++)
    begin : gSeg
      wire logic wrThis = selWrite && selIdx == 3'(g) && !nullLoadFault;
      wire logic fillThis = rspTaken && !rspAbsent && pendSeg_q == 3'(g);
      always_ff @(posedge clk or posedge reset)
      begin
        if (reset)
        begin
          selector_q[g] <= `SAT_SEL_RESET;
          cache_q[g] <= '{base: 64'h0, limit: 32'h0, access: 8'h00, longCode: 1'b0, isNull: 1'b1};
        end
        else if (clkEn)
        begin
          if (wrThis)
            selector_q[g] <= regWrData[15:0];
          // a null load marks the cache without fetching
          if (wrThis && nullLoadOk)
            cache_q[g].isNull <= 1'b1;
          // descriptor captured into the hidden part
          else if (fillThis)
          begin
            // Upper base bits cleared so narrow loads stay consistent
            cache_q[g].base <= {32'h0000_0000, rspBase};
            cache_q[g].limit <= rspLimit;
            cache_q[g].access <= rspAccess;
            cache_q[g].longCode <= rspLong;
            cache_q[g].isNull <= 1'b0;
          end
        end
      end
    end
  endgenerate

  // Operating mode
  wire logic longActive = ctrl_q[`SAT_CTRL_LONG];
  wire logic pagingOn = ctrl_q[`SAT_CTRL_PAGING];
  wire logic physExtOn = ctrlFour_q[`SAT_CTRL_FOUR_EXT];
  // current code segment decides the sub-mode
  wire logic mode64 = longActive && cache_q[SEG_CODE].longCode;
  // compatibility falls back to the legacy path
  wire logic legacyPath = !mode64;

  // Selected segment of the current reference
  wire sat_cache_s accCache = cache_q[accReq.seg];
  wire logic [1:0] accPriv = selector_q[accReq.seg][`SAT_SEL_PRIV_MSB:0];
  wire logic accAux = accReq.seg == SEG_AUX_ONE || accReq.seg == SEG_AUX_TWO;
  wire logic accSegOk = accReq.seg <= SEG_AUX_TWO;

  // legacy offset is 32 bits and base upper half ignored
  wire logic [31:0] legacyLin = accCache.base[31:0] + accReq.offset[31:0];
  wire logic [63:0] longBase = accAux ? accCache.base : 64'h0000_0000_0000_0000;
  // full 64-bit sum in 64-bit sub-mode
  wire logic [63:0] longLin = longBase + accReq.offset;
  wire logic [63:0] linAddr = legacyPath ? {32'h0000_0000, legacyLin} : longLin;

  // canonical form: upper bits copy the top implemented bit
  wire logic [63:0] canonView = 64'($signed(longLin << CANON_SHIFT) >>> CANON_SHIFT);
  wire logic canonBad = mode64 && canonView != longLin;

  // null selectors fault when used; 64-bit mode ignores data selectors
  wire logic nullUse = accCache.isNull && (legacyPath || accReq.seg == SEG_CODE);

  // access rights against the cached descriptor
  wire logic isCode = accCache.access[3];
  wire logic rwBit = accCache.access[1];
  wire logic rightsBad = legacyPath && (
    (accReq.exec && !isCode) ||
    (accReq.write && (isCode || !rwBit)) ||
    (!accReq.write && !accReq.exec && isCode && !rwBit));
  // no runtime limit check in 64-bit sub-mode
  wire logic limitBad = legacyPath && accReq.offset[31:0] > accCache.limit;

  wire logic accTaken = clkEn && accValid && accSegOk;

  // Fault priority: load faults first, then null use, canonical, rights, limit
  always_comb
  begin
    faultCode = FLT_NONE;
    if (nullLoadFault)
      faultCode = FLT_NULL_LOAD;
    else if (rspFault)
      faultCode = FLT_NOT_PRESENT;
    else if (accTaken && nullUse)
      faultCode = FLT_NULL_USE;
    else if (accTaken && canonBad)
      faultCode = FLT_CANON;
    else if (accTaken && rightsBad)
      faultCode = FLT_RIGHTS;
    else if (accTaken && limitBad)
      faultCode = FLT_LIMIT;
  end

  // fault reported in the cycle of the offending access
  assign faultValid = faultCode != FLT_NONE;
  assign faultPriv = nullLoadFault ? wrPriv : accPriv;
  wire logic accFault = accTaken && (nullUse || canonBad || rightsBad || limitBad);
  // faulting references never produce an address
  wire logic accGood = accTaken && !accFault;

  // legacy physical space is 32 bits; extension flag widens it
  wire logic [63:0] physMask = mode64 ? ~(64'hFFFF_FFFF_FFFF_FFFF << PHYS_WIDTH) :
                               physExtOn ? ~(64'hFFFF_FFFF_FFFF_FFFF << `SAT_PA_EXT) :
                               ~(64'hFFFF_FFFF_FFFF_FFFF << `SAT_PA_LEGACY);

  // Translation results stand one cycle after the reference
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      physValid_q <= 1'b0;
      physAddr_q <= 64'h0000_0000_0000_0000;
      pageValid_q <= 1'b0;
      pageAddr_q <= 64'h0000_0000_0000_0000;
    end
    else if (clkEn)
    begin
      // paging off: linear goes straight to the bus
      physValid_q <= accGood && !pagingOn;
      // paging on: second stage gets the linear address
      pageValid_q <= accGood && pagingOn;
      if (accGood && !pagingOn)
        physAddr_q <= linAddr & physMask;
      if (accGood && pagingOn)
        pageAddr_q <= linAddr;
    end
  end

  // Control and table registers
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      ctrl_q <= `SAT_CTRL_RESET;
      ctrlFour_q <= `SAT_CTRL_FOUR_RESET;
      globalBase_q <= 64'h0000_0000_0000_0000;
      localBase_q <= 64'h0000_0000_0000_0000;
    end
    else if (clkEn && regWr)
    begin
      if (hitCtrl)
        ctrl_q <= regWrData & 32'h0000_0003;
      if (hitCtrlFour)
        ctrlFour_q <= regWrData;
      if (hitGlobalLo)
        globalBase_q[31:0] <= regWrData;
      if (hitGlobalHi)
        globalBase_q[63:32] <= regWrData;
      if (hitLocalLo)
        localBase_q[31:0] <= regWrData;
      if (hitLocalHi)
        localBase_q[63:32] <= regWrData;
    end
  end

  // Last fault code stays until the next fault overwrites it
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      lastFault_q <= FLT_NONE;
    else if (clkEn && faultValid)
      lastFault_q <= faultCode;
  end

  // identification query carries the physical width in bits 7-0
  wire logic [31:0] idqWord = {24'h00_0000, 8'(PHYS_WIDTH)};
  wire logic [31:0] statusWord = {23'h00_0000, state_q == ST_FETCH, 5'h00, lastFault_q};
  wire logic [31:0] selWord = {16'h0000, selector_q[selIdx]};

  // Read selection; unmapped offsets read as zero
  wire logic [31:0] rdMux =
    hitCtrl ? ctrl_q :
    hitCtrlFour ? ctrlFour_q :
    hitGlobalLo ? globalBase_q[31:0] :
    hitGlobalHi ? globalBase_q[63:32] :
    hitLocalLo ? localBase_q[31:0] :
    hitLocalHi ? localBase_q[63:32] :
    hitIdq ? idqWord :
    hitStatus ? statusWord :
    hitSel ? selWord : 32'h0000_0000;

  // Read data valid only in the cycle after the strobe
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      rdData_q <= 32'h0000_0000;
    else if (clkEn)
      rdData_q <= regRd ? rdMux : 32'h0000_0000;
  end

  // Fetch request stands from the load until the response
  logic [63:0] descAddrHeld_q;
  assign descReqValid = state_q == ST_FETCH;
  assign descReqAddr = descAddrHeld_q;
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      descAddrHeld_q <= 64'h0000_0000_0000_0000;
    else if (clkEn && startFetch)
      descAddrHeld_q <= descAddr;
  end

  assign regRdData = rdData_q;
  assign physValid = physValid_q;
  assign physAddr = physAddr_q;
  assign pageReqValid = pageValid_q;
  assign pageLinAddr = pageAddr_q;
  assign busy = state_q == ST_FETCH;

endmodule // sat_translator

// >>> testbench/sat_assertions.sv
// Port-level checks for the segment translator
`timescale 1ns/1ps
module sat_assertions
  import sat_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic clkEn,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWr,
  input wire logic descReqValid,
  input wire logic descRspValid,
  input wire logic accValid,
  input wire sat_acc_s accReq,
  input wire logic physValid,
  input wire logic [63:0] physAddr,
  input wire logic pageReqValid,
  input wire logic faultValid,
  input wire sat_fault_e faultCode,
  input wire logic [1:0] faultPriv,
  input wire logic busy
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  // Selector load decode; writes while busy are dropped, so they are left out
  wire selWr = regWr && clkEn && !busy && regAddr >= 8'h20 && regAddr <= 8'h34;
  wire nullSel = regWrData[15:2] == 14'h0000;
  wire stackCode = regAddr == 8'h20 || regAddr == 8'h24;
  sequence sLoad;
    selWr && !nullSel;
  endsequence
  sequence sGood;
    accValid && clkEn && !faultValid && accReq.seg <= SEG_AUX_TWO;
  endsequence
  a_load_fetch: assert property (sLoad |=> descReqValid)
    else $error("selector load started no fetch");
  a_fetch_cause: assert property ($rose(descReqValid) |-> $past(selWr))
    else $error("fetch without selector load");
  a_fetch_end: assert property (clkEn && descReqValid && descRspValid |=> !descReqValid && !busy)
    else $error("fetch did not close on response");
  a_null_load: assert property (selWr && !accValid && nullSel && stackCode |->
    faultValid && faultCode == FLT_NULL_LOAD && faultPriv == regWrData[1:0])
    else $error("null load into code or stack not faulted");
  a_null_data: assert property (selWr && !accValid && nullSel && !stackCode |-> !faultValid)
    else $error("null load into data register faulted");
  a_good_out: assert property (sGood |=> physValid != pageReqValid)
    else $error("good reference gave no single address");
  a_fault_mute: assert property (accValid && faultValid |=> !physValid && !pageReqValid)
    else $error("faulted reference still gave an address");
  a_phys_width: assert property (physValid |-> physAddr[63:36] == 28'h000_0000)
    else $error("physical address too wide");
  a_hold_quiet: assert property (!clkEn |-> !faultValid)
    else $error("fault reported while clock enable low");
endmodule // sat_assertions
bind sat_translator sat_assertions u_chk (.clk(clk), .reset(reset), .clkEn(clkEn), .regAddr(regAddr),
  .regWrData(regWrData), .regWr(regWr), .descReqValid(descReqValid), .descRspValid(descRspValid),
  .accValid(accValid), .accReq(accReq), .physValid(physValid), .physAddr(physAddr),
  .pageReqValid(pageReqValid), .faultValid(faultValid), .faultCode(faultCode), .faultPriv(faultPriv), .busy(busy));

// >>> testbench/sat_desc_mem.sv
// Descriptor memory answering fetches after a set number of cycles
`timescale 1ns/1ps
module sat_desc_mem
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [3:0] lag,
  input wire logic descReqValid,
  input wire logic [63:0] descReqAddr,
  output logic descRspValid,
  output logic [63:0] descRspData
);
  logic [3:0] waitCount_q;
  // Index picks the kind: 1 legacy code, 2 long code, 3 read-only, 5 absent; base is index times 64K
  wire [7:0] idx = descReqAddr[10:3];
  wire [7:0] acc = idx == 8'h05 ? 8'h12 : idx == 8'h03 ? 8'h90 : idx inside {8'h01, 8'h02} ? 8'h9A : 8'h92;
  wire [63:0] desc = {8'h00, 2'b00, idx == 8'h02, 5'h00, acc, idx, 32'h0000_FFFF};
  // Released data line toggles so a stale word never passes for an answer
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      waitCount_q <= 4'h0;
      descRspValid <= 1'b0;
      descRspData <= 64'h0;
    end
    else
    begin
      descRspValid <= 1'b0;
      descRspData <= ~descRspData;
      waitCount_q <= descReqValid ? waitCount_q + 4'h1 : 4'h0;
      if (descReqValid && !descRspValid && waitCount_q >= lag)
      begin
        descRspValid <= 1'b1;
        descRspData <= desc;
      end
    end
  end
endmodule // sat_desc_mem

// >>> testbench/sat_translator_tb.sv
// Self-checking bench for the segment translator
`timescale 1ns/1ps
module sat_translator_tb
  import sat_pkg::*;
;
  localparam int PW = 36;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic regWr = 1'b0, regRd = 1'b0, accValid = 1'b0, pg = 1'b0;
  logic clkEn = 1'b1;
  logic [7:0] regAddr = 8'h00;
  logic [31:0] regWrData = 32'h0000_0000;
  logic [3:0] lag = 4'h0;
  sat_acc_s accReq = '0;
  logic [31:0] regRdData;
  logic descReqValid, descRspValid, physValid, pageReqValid, faultValid, busy;
  logic [63:0] descReqAddr, descRspData, physAddr, pageLinAddr;
  sat_fault_e faultCode;
  logic [1:0] faultPriv;
  int mismatches = 0;
  int checks_done = 0;
  // Half period of the 40 MHz clock
  always #12.5 clk = ~clk;
  sat_translator #(.PHYS_WIDTH(PW)) u_dut (.clk(clk), .reset(reset), .clkEn(clkEn), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .descReqValid(descReqValid),
    .descReqAddr(descReqAddr), .descRspValid(descRspValid), .descRspData(descRspData), .accValid(accValid),
    .accReq(accReq), .physValid(physValid), .physAddr(physAddr), .pageReqValid(pageReqValid),
    .pageLinAddr(pageLinAddr), .faultValid(faultValid), .faultCode(faultCode), .faultPriv(faultPriv), .busy(busy));
  sat_desc_mem u_mem (.clk(clk), .reset(reset), .lag(lag), .descReqValid(descReqValid),
    .descReqAddr(descReqAddr), .descRspValid(descRspValid), .descRspData(descRspData));
  // Compare, count and report
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks=%0d mismatches=%0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Fault outputs are combinational, so they are judged mid-cycle
  task automatic fchk(input sat_fault_e f);
    chk(64'(faultValid), 64'(f != FLT_NONE));
    if (f != FLT_NONE)
      chk(64'(faultCode), 64'(f));
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input sat_fault_e f);
    @(posedge clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(negedge clk);
    fchk(f);
    @(posedge clk);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'b0;
    @(negedge clk);
    chk(64'(regRdData), 64'(e));
  endtask
  // Selector load with a bounded wait for the fetch to close
  task automatic ld(input logic [7:0] a, input logic [15:0] s, input logic [63:0] ea, input sat_fault_e f);
    int i;
    wr(a, {16'h0000, s}, FLT_NONE);
    @(negedge clk);
    chk(64'(descReqValid), 64'h1);
    chk(descReqAddr, ea);
    for (i = 0; i < 40 && busy !== 1'b0; i++)
    begin
      if (descRspValid === 1'b1)
        fchk(f);
      @(negedge clk);
    end
    if (i == 40)
    begin
      mismatches++;
      tally_and_finish();
    end
  endtask
  task automatic acc(input sat_seg_e s, input logic [63:0] o, input logic w, input logic x,
    input sat_fault_e f, input logic [63:0] ea);
    @(posedge clk);
    accValid <= 1'b1;
    accReq <= '{s, o, w, x};
    @(negedge clk);
    fchk(f);
    @(posedge clk);
    accValid <= 1'b0;
    @(negedge clk);
    chk(64'(physValid), 64'(f == FLT_NONE && !pg));
    chk(64'(pageReqValid), 64'(f == FLT_NONE && pg));
    if (f == FLT_NONE)
      chk(pg ? pageLinAddr : physAddr, ea);
  endtask
  task automatic t_null;
    rd(8'h00, 32'h0000_0000);
    rd(8'h18, 32'(PW));
    rd(8'h40, 32'h0000_0000);
    wr(8'h04, 32'h0000_0020, FLT_NONE);
    rd(8'h04, 32'h0000_0020);
    acc(SEG_DATA, 64'h100, 1'b0, 1'b0, FLT_NULL_USE, 64'h0);
    wr(8'h20, 32'h0000_0003, FLT_NULL_LOAD);
    wr(8'h24, 32'h0000_0000, FLT_NULL_LOAD);
    rd(8'h20, 32'h0000_0000);
    wr(8'h2C, 32'h0000_0001, FLT_NONE);
    rd(8'h2C, 32'h0000_0001);
    acc(SEG_EXTRA, 64'h0, 1'b0, 1'b0, FLT_NULL_USE, 64'h0);
    rd(8'h1C, 32'h0000_0002);
    $display("test null done");
  endtask
  task automatic t_legacy;
    wr(8'h08, 32'h0000_8000, FLT_NONE);
    wr(8'h10, 32'h0001_0000, FLT_NONE);
    ld(8'h28, 16'h0023, 64'h8020, FLT_NONE);
    acc(SEG_DATA, 64'h100, 1'b0, 1'b0, FLT_NONE, 64'h4_0100);
    acc(SEG_DATA, 64'h1_0000_FFFF, 1'b1, 1'b0, FLT_NONE, 64'h4_FFFF);
    acc(SEG_DATA, 64'h1_0000, 1'b0, 1'b0, FLT_LIMIT, 64'h0);
    acc(SEG_DATA, 64'h10, 1'b0, 1'b1, FLT_RIGHTS, 64'h0);
    ld(8'h2C, 16'h0034, 64'h1_0030, FLT_NONE);
    acc(SEG_EXTRA, 64'h10, 1'b0, 1'b0, FLT_NONE, 64'h6_0010);
    ld(8'h2C, 16'h001C, 64'h1_0018, FLT_NONE);
    acc(SEG_EXTRA, 64'h4, 1'b1, 1'b0, FLT_RIGHTS, 64'h0);
    lag <= 4'h6;
    ld(8'h30, 16'h0028, 64'h8028, FLT_NOT_PRESENT);
    acc(SEG_AUX_ONE, 64'h0, 1'b0, 1'b0, FLT_NULL_USE, 64'h0);
    lag <= 4'h1;
    pg = 1'b1;
    wr(8'h00, 32'h0000_0002, FLT_NONE);
    acc(SEG_DATA, 64'h200, 1'b0, 1'b0, FLT_NONE, 64'h4_0200);
    pg = 1'b0;
    wr(8'h00, 32'h0000_0000, FLT_NONE);
    $display("test legacy done");
  endtask
  task automatic t_long;
    ld(8'h20, 16'h0010, 64'h8010, FLT_NONE);
    ld(8'h34, 16'h0030, 64'h8030, FLT_NONE);
    wr(8'h00, 32'h0000_0001, FLT_NONE);
    acc(SEG_DATA, 64'h12_3456_789A, 1'b0, 1'b0, FLT_NONE, 64'h2_3456_789A);
    acc(SEG_EXTRA, 64'h40, 1'b1, 1'b0, FLT_NONE, 64'h40);
    acc(SEG_AUX_TWO, 64'h10, 1'b0, 1'b0, FLT_NONE, 64'h6_0010);
    acc(SEG_DATA, 64'h1_0000_0000_0000, 1'b0, 1'b0, FLT_CANON, 64'h0);
    ld(8'h20, 16'h0008, 64'h8008, FLT_NONE);
    acc(SEG_DATA, 64'h1_0000, 1'b0, 1'b0, FLT_LIMIT, 64'h0);
    acc(SEG_DATA, 64'h100, 1'b0, 1'b0, FLT_NONE, 64'h4_0100);
    wr(8'h00, 32'h0000_0000, FLT_NONE);
    $display("test long done");
  endtask
  // Clock enable low: a faulting reference and a selector load leave no trace
  task automatic t_hold;
    @(posedge clk);
    clkEn <= 1'b0;
    accValid <= 1'b1;
    accReq <= '{SEG_DATA, 64'h1_0000, 1'b0, 1'b0};
    @(negedge clk);
    chk(64'(faultValid), 64'h0);
    @(posedge clk);
    accValid <= 1'b0;
    regWr <= 1'b1;
    regAddr <= 8'h28;
    regWrData <= 32'h0000_0018;
    @(posedge clk);
    regWr <= 1'b0;
    @(negedge clk);
    chk(64'(physValid), 64'h0);
    chk(64'(busy), 64'h0);
    @(posedge clk);
    clkEn <= 1'b1;
    rd(8'h28, 32'h0000_0023);
    $display("test hold done");
  endtask
  // Reset held for 12 cycles, then the scenarios in turn
  initial
  begin
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    t_null();
    t_legacy();
    t_long();
    t_hold();
    tally_and_finish();
  end
endmodule // sat_translator_tb
